// ===== bench/url_far_tx.sv
// remote serial transmitter model that feeds the receive line status block
// assumes the bench calls hold and send from its main sequence, one caller
`timescale 1ns/1ps

module url_far_tx (
	input wire logic core_clk,
	input wire logic resetn,
	output logic rx_tick16,
	output logic serial_rx_input
);
	logic tick_div;

	// ----------------------------------------
	// 16x tick and line drive
	// ----------------------------------------
	// one tick every second cycle keeps frames short but still sixteen ticks a bit
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			tick_div <= 1'b0;
			rx_tick16 <= 1'b0;
		end else begin
			tick_div <= ~tick_div;
			// stands in for the host-set baud divisor, which only stretches the tick
			rx_tick16 <= tick_div;
		end
	end

	// idle line rests at marking, as a released line would
	initial serial_rx_input = 1'b1;

	// level changes only on a tick edge, so a bit spans whole ticks
	task automatic hold(input logic v, input int ticks);
		for (int i = 0; i < ticks; i++) begin
			do @(posedge core_clk); while (rx_tick16 !== 1'b1);
			if (i == 0) begin
				serial_rx_input <= v;
			end
		end
	endtask

	// lsb first, sixteen ticks per bit
	task automatic send(input logic [11:0] bits, input int n);
		for (int k = 0; k < n; k++) begin
			hold(bits[k], 16);
		end
	endtask
endmodule

// ===== bench/url_rx_line_status_tb.sv
// self-checking bench of the receive line status block
// assumes the design asserts its own rules; the bench drives bus and line
`timescale 1ns/1ps
`include "url_params.svh"

module url_rx_line_status_tb;
	logic core_clk, resetn, bus_wr, bus_rd, rx_tick16, serial_rx_input;
	logic rx_char_waiting, rx_line_irq;
	logic [2:0] bus_addr;
	logic [7:0] bus_wdata, bus_rdata;
	logic [1:0] len;
	logic pen, even, stick;
	logic [31:0] seed = 32'h0000418e;
	int err_count = 0;
	int total_checks = 0;
	int cycles = 0;

	url_rx_line_status #(.DEPTH(4)) i_dut (.core_clk(core_clk), .resetn(resetn),
		.bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
		.bus_rdata(bus_rdata), .rx_tick16(rx_tick16), .serial_rx_input(serial_rx_input),
		.rx_char_waiting(rx_char_waiting), .rx_line_irq(rx_line_irq));
	url_far_tx u_far (.core_clk(core_clk), .resetn(resetn), .rx_tick16(rx_tick16),
		.serial_rx_input(serial_rx_input));

	// ----------------------------------------
	// clock, timeout, verdict
	// ----------------------------------------
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	task automatic tally_and_finish();
		if (err_count == 0 && total_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// ceiling well above the fewer than 10k cycles the sequence needs
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 60000) begin
			err_count++;
			$display("mismatch at %0t: run hung", $time);
			tally_and_finish();
		end
	end

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge core_clk);
		bus_wr <= 1'b1;
		bus_addr <= a;
		bus_wdata <= d;
		@(posedge core_clk);
		bus_wr <= 1'b0;
	endtask

	// two lead edges let head tags settle before the read is taken
	task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
		repeat (2) @(posedge core_clk);
		bus_rd <= 1'b1;
		bus_addr <= a;
		@(posedge core_clk);
		bus_rd <= 1'b0;
		#1 chk(bus_rdata, exp);
	endtask

	function automatic logic [7:0] mask(input logic [7:0] d);
		// a 3-bit sum would wrap to zero at 8-bit length and mask everything
		return d & ~(8'hff << (4'h5 + len));
	endfunction

	// start, data lsb first, optional parity, one stop
	function automatic logic [11:0] frame(input logic [7:0] d, input logic bad_par,
		input logic stop, output int n);
		logic [11:0] f;
		f = 12'h000;
		n = 1;
		for (int i = 0; i < 5 + len; i++) begin
			f[n] = d[i];
			n++;
		end
		if (pen) begin
			// stick parity sends the inverse of even-select as a fixed bit
			f[n] = (stick ? ~even : (even ? ^mask(d) : ~^mask(d))) ^ bad_par;
			n++;
		end
		f[n] = stop;
		n++;
		return f;
	endfunction

	task automatic fmt(input logic [1:0] l, input logic p, input logic e, input logic s2);
		len = l;
		pen = p;
		even = e;
		wr(`URL_OFF_FORMAT, {2'h0, stick, e, p, s2, l});
	endtask

	task automatic tx(input logic [7:0] d, input logic bad_par, input logic stop);
		logic [11:0] f;
		int n;
		f = frame(d, bad_par, stop, n);
		u_far.send(f, n);
		u_far.hold(1'b1, 4);
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		logic [31:0] r;
		logic [7:0] d;
		logic [11:0] f;
		int n;
		resetn = 1'b0;
		bus_wr = 1'b0;
		bus_rd = 1'b0;
		bus_addr = 3'h0;
		bus_wdata = 8'h00;
		stick = 1'b0;
		repeat (10) @(posedge core_clk);
		resetn <= 1'b1;
		rd_chk(`URL_OFF_STATUS, 8'h00);
		rd_chk(`URL_OFF_FORMAT, `URL_FORMAT_RESET);
		wr(3'h7, 8'hff);
		rd_chk(3'h7, 8'h00);
		chk({6'h00, rx_line_irq, rx_char_waiting}, 8'h00);
		// holding mode: random formats, parity and stop faults
		for (int it = 0; it < 12; it++) begin
			r = xs();
			stick = r[9];
			fmt(r[1:0], r[2], r[3], r[4]);
			wr(`URL_OFF_INTEN, {7'h00, r[5]});
			d = r[23:16] | 8'h01;
			tx(d, r[6], ~(r[7] & r[8]));
			chk({7'h00, rx_char_waiting}, 8'h01);
			chk({7'h00, rx_line_irq}, {7'h00, r[5] & ((r[2] & r[6]) | (r[7] & r[8]))});
			rd_chk(`URL_OFF_STATUS, {4'h0, r[7] & r[8], r[2] & r[6], 2'b01});
			rd_chk(`URL_OFF_STATUS, 8'h01);
			rd_chk(`URL_OFF_RXBUF, mask(d));
			rd_chk(`URL_OFF_STATUS, 8'h00);
		end
		stick = 1'b0;
		// holding mode overrun: second character replaces the unread first
		wr(`URL_OFF_INTEN, 8'h01);
		fmt(2'h3, 1'b0, 1'b0, 1'b0);
		tx(8'h5a, 1'b0, 1'b1);
		tx(8'ha5, 1'b0, 1'b1);
		chk({7'h00, rx_line_irq}, 8'h01);
		rd_chk(`URL_OFF_STATUS, 8'h03);
		rd_chk(`URL_OFF_STATUS, 8'h01);
		rd_chk(`URL_OFF_RXBUF, 8'ha5);
		// fifo mode: low stop taken as the next start, held half a bit more
		wr(`URL_OFF_FIFOCTL, 8'h01);
		f = frame(8'h81, 1'b0, 1'b0, n);
		u_far.send(f, n);
		u_far.hold(1'b0, 8);
		f = frame(8'h3c, 1'b0, 1'b1, n);
		u_far.send(f >> 1, n - 1);
		u_far.hold(1'b1, 4);
		rd_chk(`URL_OFF_STATUS, 8'h09);
		rd_chk(`URL_OFF_RXBUF, 8'h81);
		rd_chk(`URL_OFF_STATUS, 8'h01);
		rd_chk(`URL_OFF_RXBUF, 8'h3c);
		// fill a four-deep fifo, second entry with a parity fault, then one more
		fmt(2'h3, 1'b1, 1'b1, 1'b0);
		for (int k = 1; k <= 4; k++) begin
			tx(8'h11 * k, k == 2, 1'b1);
		end
		rd_chk(`URL_OFF_STATUS, 8'h01);
		tx(8'h55, 1'b0, 1'b1);
		rd_chk(`URL_OFF_STATUS, 8'h03);
		rd_chk(`URL_OFF_RXBUF, 8'h11);
		chk({7'h00, rx_char_waiting}, 8'h01);
		rd_chk(`URL_OFF_STATUS, 8'h05);
		for (int k = 2; k <= 4; k++) begin
			rd_chk(`URL_OFF_RXBUF, 8'h11 * k);
		end
		rd_chk(`URL_OFF_STATUS, 8'h00);
		// break longer than a frame: one zero entry, then a normal character
		u_far.hold(1'b0, 16 * 14);
		u_far.hold(1'b1, 4);
		chk({7'h00, rx_line_irq}, 8'h01);
		rd_chk(`URL_OFF_STATUS, 8'h19);
		chk({7'h00, rx_line_irq}, 8'h00);
		rd_chk(`URL_OFF_RXBUF, 8'h00);
		rd_chk(`URL_OFF_STATUS, 8'h00);
		tx(8'h6b, 1'b0, 1'b1);
		rd_chk(`URL_OFF_RXBUF, 8'h6b);
		// flush bit empties the fifo with a character still waiting
		tx(8'h77, 1'b0, 1'b1);
		chk({7'h00, rx_char_waiting}, 8'h01);
		wr(`URL_OFF_FIFOCTL, 8'h03);
		rd_chk(`URL_OFF_STATUS, 8'h00);
		tally_and_finish();
	end
endmodule

// ===== shared/url_params.svh
// register offsets, field positions, reset values and sample points of the
// receive line status block; assumes a 3-bit register address and 8-bit data
`ifndef URL_PARAMS_SVH
`define URL_PARAMS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define URL_OFF_RXBUF 3'h0
`define URL_OFF_INTEN 3'h1
`define URL_OFF_FIFOCTL 3'h2
`define URL_OFF_FORMAT 3'h3
`define URL_OFF_STATUS 3'h5

// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define URL_ST_READY 0
`define URL_ST_OVERRUN 1
`define URL_ST_PARITY 2
`define URL_ST_STOP 3
`define URL_ST_BREAK 4
`define URL_FC_ENABLE 0
`define URL_FC_CLEAR 1
`define URL_IE_LINE 0
`define URL_FORMAT_RESET 8'h00
`define URL_INTEN_RESET 1'b0
`define URL_FIFOEN_RESET 1'b0

// ----------------------------------------
// 16x sample points within one bit
// ----------------------------------------
`define URL_MID_TICK 4'h7
`define URL_BIT_TICK 4'hf

`endif

// ===== shared/url_pkg.sv
// types shared by the receive line status block
// assumes nothing beyond a SystemVerilog compiler
package url_pkg;

	// receiver states, one-hot
	typedef enum logic [5:0] {
		URL_IDLE = 6'h01,
		URL_START = 6'h02,
		URL_DATA = 6'h04,
		URL_PAR = 6'h08,
		URL_STOP = 6'h10,
		URL_BRK = 6'h20
	} url_state_e;

	// one received character with its own error tags
	typedef struct packed {
		logic brk;
		logic bad_stop;
		logic par_bad;
		logic [7:0] data;
	} url_entry_s;

	// line format register layout
	typedef struct packed {
		logic div_access;
		logic brk_ctl;
		logic stick;
		logic even_sel;
		logic par_en;
		logic stop2;
		logic [1:0] len;
	} url_format_s;

endpackage

// ===== src/url_rx_line_status.sv
// receive side of an async serial port: deserialiser, receive fifo with
// per-character error tags, line status flags and line status interrupt
// assumes rx_tick16 is a one-cycle pulse at 16x baud, inputs synchronous
`timescale 1ns/1ps
`include "url_params.svh"

// Overview of operation
// - set data-ready once a whole character lands in holding register or fifo
// - data-ready clears when every held character has been read or the fifo is flushed
// - non-fifo: new character over unread one sets overrun, old one lost
// - overrun flag set on overrun, cleared by status register read
// - fifo overrun only when full and another character fully assembled
// - fifo overrun flagged at once; character dropped, fifo untouched
// - parity flag when received parity mismatches selected even or odd
// - parity flag set on detection, cleared by status register read
// - fifo mode: error tags travel with character, shown at fifo head
// - framing flag when first stop bit is sampled low
// - framing flag cleared by status register read
// - after framing error, low stop taken as start, sampled twice
// - break flag when input held low longer than one character time
// - break flag cleared by status register read
// - break loads one zero character, then waits for marking and new start
// - line status interrupt on overrun, parity, framing or break if enabled
// - only the first stop bit is checked for framing
// - even-select 0 expects odd parity, 1 expects even, when enabled
module url_rx_line_status #(
	parameter int DEPTH = 16
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic [2:0] bus_addr,
	input wire logic [7:0] bus_wdata,
	input wire logic bus_wr,
	input wire logic bus_rd,
	output logic [7:0] bus_rdata,
	input wire logic rx_tick16,
	input wire logic serial_rx_input,
	output logic rx_char_waiting,
	output logic rx_line_irq
);

	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	// ----------------------------------------
	// declarations
	// ----------------------------------------
	url_pkg::url_state_e state;
	url_pkg::url_format_s fmt;
	url_pkg::url_entry_s push_entry;
	url_pkg::url_entry_s head;
	url_pkg::url_entry_s mem [DEPTH];
	logic [3:0] tick_cnt;
	logic [2:0] bit_idx;
	logic [2:0] last_idx;
	logic [7:0] shift;
	logic [7:0] aligned;
	logic par_acc;
	logic par_err;
	logic all_low;
	logic push_req;
	logic line_ie;
	logic fifo_en;
	logic [PW-1:0] wr_ptr;
	logic [PW-1:0] rd_ptr;
	logic [CW-1:0] count;
	logic full;
	logic pop;
	logic push_acc;
	logic over_wr;
	logic overrun;
	logic fifo_clr;
	logic head_fresh;
	logic lsr_rd;
	logic oe_flag;
	logic pe_flag;
	logic fe_flag;
	logic bi_flag;

	// ----------------------------------------
	// bus decode
	// ----------------------------------------
	assign lsr_rd = bus_rd && (bus_addr == `URL_OFF_STATUS);
	assign pop = bus_rd && (bus_addr == `URL_OFF_RXBUF) && (count != '0);
	// leaving or entering fifo mode flushes, as does the clear bit
	assign fifo_clr = bus_wr && (bus_addr == `URL_OFF_FIFOCTL) &&
		(bus_wdata[`URL_FC_CLEAR] || (bus_wdata[`URL_FC_ENABLE] != fifo_en));

	// ----------------------------------------
	// control registers
	// ----------------------------------------
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			fmt <= `URL_FORMAT_RESET;
			line_ie <= `URL_INTEN_RESET;
			fifo_en <= `URL_FIFOEN_RESET;
		end else if (bus_wr) begin
			case (bus_addr)
				`URL_OFF_FORMAT: fmt <= bus_wdata;
				`URL_OFF_INTEN: line_ie <= bus_wdata[`URL_IE_LINE];
				`URL_OFF_FIFOCTL: fifo_en <= bus_wdata[`URL_FC_ENABLE];
				default: ;
			endcase
		end
	end

	// ----------------------------------------
	// deserialiser
	// ----------------------------------------
	assign last_idx = 3'h4 + {1'b0, fmt.len};
	// characters shorter than 8 bits arrive lsb first, so shift down
	assign aligned = shift >> (2'h3 - fmt.len);

	// one state update per 16x tick; framing only on first stop bit
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			state <= url_pkg::URL_IDLE;
			tick_cnt <= 4'h0;
			bit_idx <= 3'h0;
			shift <= 8'h00;
			par_acc <= 1'b0;
			par_err <= 1'b0;
			all_low <= 1'b0;
			push_req <= 1'b0;
			push_entry <= '0;
		end else begin
			push_req <= 1'b0;
			if (rx_tick16) begin
				case (state)
					url_pkg::URL_IDLE: begin
						if (!serial_rx_input) begin
							state <= url_pkg::URL_START;
							tick_cnt <= 4'h0;
						end
					end
					url_pkg::URL_START: begin
						// mid-bit check rejects glitches as false starts
						if (tick_cnt == `URL_MID_TICK) begin
							tick_cnt <= 4'h0;
							bit_idx <= 3'h0;
							par_acc <= 1'b0;
							par_err <= 1'b0;
							all_low <= 1'b1;
							state <= serial_rx_input ? url_pkg::URL_IDLE : url_pkg::URL_DATA;
						end else begin
							tick_cnt <= tick_cnt + 4'h1;
						end
					end
					url_pkg::URL_DATA: begin
						if (tick_cnt == `URL_BIT_TICK) begin
							tick_cnt <= 4'h0;
							shift <= {serial_rx_input, shift[7:1]};
							par_acc <= par_acc ^ serial_rx_input;
							all_low <= all_low & ~serial_rx_input;
							bit_idx <= bit_idx + 3'h1;
							if (bit_idx == last_idx) begin
								state <= fmt.par_en ? url_pkg::URL_PAR : url_pkg::URL_STOP;
							end
						end else begin
							tick_cnt <= tick_cnt + 4'h1;
						end
					end
					url_pkg::URL_PAR: begin
						if (tick_cnt == `URL_BIT_TICK) begin
							tick_cnt <= 4'h0;
							all_low <= all_low & ~serial_rx_input;
							state <= url_pkg::URL_STOP;
							if (fmt.stick) begin
								par_err <= (serial_rx_input == fmt.even_sel);
							end else begin
								par_err <= (par_acc ^ serial_rx_input) ^ ~fmt.even_sel;
							end
						end else begin
							tick_cnt <= tick_cnt + 4'h1;
						end
					end
					url_pkg::URL_STOP: begin
						if (tick_cnt == `URL_BIT_TICK) begin
							tick_cnt <= 4'h0;
							push_req <= 1'b1;
							push_entry.data <= aligned;
							push_entry.par_bad <= par_err;
							push_entry.bad_stop <= ~serial_rx_input;
							// whole frame low, stop included, is a break
							push_entry.brk <= all_low & ~serial_rx_input;
							if (serial_rx_input) begin
								state <= url_pkg::URL_IDLE;
							end else if (all_low) begin
								state <= url_pkg::URL_BRK;
							end else begin
								// low stop taken as next start, checked once more
								state <= url_pkg::URL_START;
							end
						end else begin
							tick_cnt <= tick_cnt + 4'h1;
						end
					end
					url_pkg::URL_BRK: begin
						// no characters until line returns to marking
						if (serial_rx_input) begin
							state <= url_pkg::URL_IDLE;
						end
					end
					default: state <= url_pkg::URL_IDLE;
				endcase
			end
		end
	end

	// ----------------------------------------
	// receive fifo (depth 1 in holding register mode)
	// ----------------------------------------
	assign full = fifo_en ? (count == CW'(DEPTH)) : (count != '0);
	assign push_acc = push_req && (!full || pop);
	assign overrun = push_req && full && !pop;
	// holding mode replaces the unread character; fifo mode drops the new one
	assign over_wr = overrun && !fifo_en;
	assign head = mem[rd_ptr];

	// storage needs no reset; empty slots are never shown
	always_ff @(posedge core_clk) begin
		if (push_acc) begin
			mem[wr_ptr] <= push_entry;
		end else if (over_wr) begin
			mem[rd_ptr] <= push_entry;
		end
	end

	// pointers and fill count
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else if (fifo_clr) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (push_acc) begin
				wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + PW'(1);
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + PW'(1);
			end
			if (push_acc && !pop) begin
				count <= count + CW'(1);
			end else if (pop && !push_acc) begin
				count <= count - CW'(1);
			end
		end
	end

	// a new character reached the head; its tags show one cycle later
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			head_fresh <= 1'b0;
		end else begin
			head_fresh <= !fifo_clr && ((push_acc && (count == '0 ||
				(pop && count == CW'(1)))) || (pop && count > CW'(1)) || over_wr);
		end
	end

	// ----------------------------------------
	// status flags: set beats the clearing read
	// ----------------------------------------
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			oe_flag <= 1'b0;
		end else if (overrun) begin
			oe_flag <= 1'b1;
		end else if (lsr_rd) begin
			oe_flag <= 1'b0;
		end
	end

	// error tags of the head character
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			pe_flag <= 1'b0;
			fe_flag <= 1'b0;
			bi_flag <= 1'b0;
		end else begin
			pe_flag <= (head_fresh && head.par_bad) || (pe_flag && !lsr_rd);
			fe_flag <= (head_fresh && head.bad_stop) || (fe_flag && !lsr_rd);
			bi_flag <= (head_fresh && head.brk) || (bi_flag && !lsr_rd);
		end
	end

	assign rx_char_waiting = (count != '0);
	assign rx_line_irq = line_ie && (oe_flag || pe_flag || fe_flag || bi_flag);

	// ----------------------------------------
	// read data, one cycle after the strobe
	// ----------------------------------------
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			bus_rdata <= 8'h00;
		end else if (bus_rd) begin
			case (bus_addr)
				`URL_OFF_RXBUF: bus_rdata <= (count != '0) ? head.data : 8'h00;
				`URL_OFF_INTEN: bus_rdata <= {7'h00, line_ie};
				`URL_OFF_FORMAT: bus_rdata <= fmt;
				// pre-read values; clearing lands on the same edge
				`URL_OFF_STATUS: bus_rdata <= {3'h0, bi_flag, fe_flag, pe_flag,
					oe_flag, rx_char_waiting};
				default: bus_rdata <= 8'h00;
			endcase
		end else begin
			bus_rdata <= 8'h00;
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	dr_set_a: assert property (@(posedge core_clk) disable iff (!resetn)
		push_acc && !fifo_clr |=> rx_char_waiting)
		else $error("data ready not set after character stored");

	dr_clear_a: assert property (@(posedge core_clk) disable iff (!resetn)
		pop && count == CW'(1) && !push_acc |=> !rx_char_waiting)
		else $error("data ready still set after last character read");

	hold_overrun_a: assert property (@(posedge core_clk) disable iff (!resetn)
		push_req && !fifo_en && count != '0 && !pop && !fifo_clr
		|=> oe_flag && count == CW'(1))
		else $error("holding register overrun not flagged");

	fifo_drop_a: assert property (@(posedge core_clk) disable iff (!resetn)
		push_req && fifo_en && full && !pop && !fifo_clr
		|=> oe_flag && count == $past(count) && wr_ptr == $past(wr_ptr))
		else $error("fifo overrun wrote into full fifo or went unflagged");

	no_early_ovr_a: assert property (@(posedge core_clk) disable iff (!resetn)
		!oe_flag && fifo_en && count < CW'(DEPTH) && !lsr_rd |=> !oe_flag)
		else $error("overrun raised while fifo not full");

	status_clear_a: assert property (@(posedge core_clk) disable iff (!resetn)
		lsr_rd && !overrun && !head_fresh
		|=> !oe_flag && !pe_flag && !fe_flag && !bi_flag
		&& bus_rdata[`URL_ST_OVERRUN] == $past(oe_flag))
		else $error("status read did not report then clear flags");

	parity_tag_a: assert property (@(posedge core_clk) disable iff (!resetn)
		head_fresh && head.par_bad |=> pe_flag ##1 (pe_flag || $past(lsr_rd)))
		else $error("parity tag of head character not shown");

	resync_a: assert property (@(posedge core_clk) disable iff (!resetn)
		rx_tick16 && state == url_pkg::URL_STOP && tick_cnt == `URL_BIT_TICK
		&& !serial_rx_input && !all_low |=> state == url_pkg::URL_START && tick_cnt == 4'h0)
		else $error("no resync after framing error");

	break_hold_a: assert property (@(posedge core_clk) disable iff (!resetn)
		state == url_pkg::URL_BRK |=> !push_req)
		else $error("character accepted during break");

	irq_overrun_a: assert property (@(posedge core_clk) disable iff (!resetn)
		overrun && line_ie && !(bus_wr && bus_addr == `URL_OFF_INTEN) |=> rx_line_irq)
		else $error("line status interrupt missing after overrun");

endmodule
